// >>> design/pin_route_consts.svh
/*
 Register offsets, field positions, reset values and sizes of the remappable pin routing block.
 Assumes inclusion by bare name from any design or bench file.
*/
`ifndef PIN_ROUTE_CONSTS_SVH
`define PIN_ROUTE_CONSTS_SVH

`define N_IN_SEL 21
`define N_OUT_PIN 13
`define N_PINS 14
`define N_PERIPH_OUT 16
`define SEL_W 4
`define ADDR_W 8

`define OFF_CONFIG_CONTROL 8'h00
`define OFF_UNLOCK_KEY 8'h04
`define OFF_STATUS 8'h08
`define OFF_IN_SEL_BASE 8'h40
`define OFF_OUT_SEL_BASE 8'hc0

`define BIT_MAP_WRITE_LOCK 13
`define UNLOCK_KEY_FIRST 32'haa996655
`define UNLOCK_KEY_SECOND 32'h556699aa
`define FIRST_RESTRICTED_CODE 4'hb
`define FIRST_RESERVED_CODE 4'he
`define SEL_RESET 4'h0

`endif

// >>> design/pin_route_pkg.sv
/*
 Types shared by the remappable pin routing block.
 Assumes pin_route_consts.svh is on the include path.
*/
`default_nettype none
`include "pin_route_consts.svh"
package pin_route_pkg;
  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_HALF = 3'b010,
    KEY_OPEN = 3'b100
  } unlock_state_t;

  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } wb_req_t;
endpackage
`default_nettype wire

// >>> design/remappable_pin_routing.sv
/*
 Remappable pin routing: per-input and per-pin 4-bit select registers behind a classic
 Wishbone slave, guarded by an unlock key sequence, a write-lock bit and a single-session lock.
 Assumes pin inputs arrive asynchronously; peripheral outputs come from logic on core_clk.
*/
//
// Overview of operation
// - Each peripheral input has a 4-bit select whose codes 0 to 13 route one pin, 14 and 15 reserved.
// - On the 64-pin package, input codes naming absent pins are treated as unavailable.
// - Remappable pins 0 to 12 each have their own output select register deciding which peripheral output drives them; pin 13 has none.
// - Output select registers hold 4-bit fields laid out like the input selects.
// - Each nonzero output select value drives exactly one peripheral output onto its pin.
// - Output select 0, the reset value, is a null output so pins start disconnected.
// - The map can change at run time, guarded by an unlock-controlled lock and a configuration lock.
// - While the write-lock bit is set, select register writes are acknowledged but ignored.
// - The write-lock bit may only be set or cleared after the unlock sequence.
// - With single-session lock set, the write-lock bit cannot be cleared once set, until reset.
// - The single-session lock defaults to set when unprogrammed.
`timescale 1ns/10ps
`default_nettype none
`include "pin_route_consts.svh"
module remappable_pin_routing (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Wishbone slave.
  input wire pin_route_pkg::wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Configuration straps.
  input wire logic single_session_lock,
  input wire logic pkg_64_pin,
  // Pins and peripherals.
  input wire logic [`N_PINS-1:0] pin_in,
  output logic [`N_OUT_PIN-1:0] pin_out,
  output logic [`N_OUT_PIN-1:0] pin_oe,
  input wire logic [`N_PERIPH_OUT-1:0] periph_out,
  output logic [`N_IN_SEL-1:0] periph_in
);

  ////////////////////////////////////////////////////////////////////////////
  logic [`SEL_W-1:0] in_sel [`N_IN_SEL];
  logic [`SEL_W-1:0] out_sel [`N_OUT_PIN];
  logic map_write_lock;
  logic one_way;
  logic small_pkg;
  logic strap_taken;
  logic lock_was_set;
  pin_route_pkg::unlock_state_t key_state;
  logic [`N_PINS-1:0] pin_meta;
  logic [`N_PINS-1:0] pin_sync;
  logic req;
  logic wr;
  logic [7:0] a;

  // Word-aligned address map: the control word holding the write-lock bit, the key port, a read-only
  // status word, one word per input select and, above those, one word per output select. Every select
  // field lives in the lowest byte, so only the first byte lane enables a select write. A request is taken
  // while the acknowledge is low, which keeps a held strobe from being taken twice.
  assign req = wb_req.cyc & wb_req.stb & ~wb_ack_o;
  assign wr = req & wb_req.we;
  assign a = wb_req.adr[`ADDR_W-1:0];

  // Straps are caught at the first edge after reset release; the undriven default is a set lock.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken <= 1'b0;
      one_way <= 1'b1;
      small_pkg <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      one_way <= single_session_lock;
      small_pkg <= pkg_64_pin;
    end
  end

  // Until the straps are caught the single-session lock must already read as set.
  a_session_default: assert property (@(posedge core_clk) disable iff (!rst_n)
    !strap_taken |-> one_way)
    else $error("Single-session lock not set before the straps are caught.");

  ////////////////////////////////////////////////////////////////////////////
  // Unlock key: two key words in consecutive writes open one lock-bit write.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_state <= pin_route_pkg::KEY_IDLE;
    end else if (wr) begin
      case (key_state)
        pin_route_pkg::KEY_IDLE: begin
          if (a == `OFF_UNLOCK_KEY && wb_req.dat == `UNLOCK_KEY_FIRST) begin
            key_state <= pin_route_pkg::KEY_HALF;
          end
        end
        pin_route_pkg::KEY_HALF: begin
          if (a == `OFF_UNLOCK_KEY && wb_req.dat == `UNLOCK_KEY_SECOND) begin
            key_state <= pin_route_pkg::KEY_OPEN;
          end else begin
            key_state <= pin_route_pkg::KEY_IDLE;
          end
        end
        pin_route_pkg::KEY_OPEN: begin
          key_state <= pin_route_pkg::KEY_IDLE;
        end
        default: begin
          key_state <= pin_route_pkg::KEY_IDLE;
        end
      endcase
    end
  end

  // The open window lasts for exactly one bus write, whatever that write is.
  a_key_first_word: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && key_state == pin_route_pkg::KEY_IDLE && a == `OFF_UNLOCK_KEY && wb_req.dat == `UNLOCK_KEY_FIRST)
    |=> key_state == pin_route_pkg::KEY_HALF)
    else $error("First key word did not advance the unlock sequence.");

  a_key_second_word: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && key_state == pin_route_pkg::KEY_HALF && a == `OFF_UNLOCK_KEY && wb_req.dat == `UNLOCK_KEY_SECOND)
    |=> key_state == pin_route_pkg::KEY_OPEN)
    else $error("Second key word did not open the lock window.");

  a_key_half_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && key_state == pin_route_pkg::KEY_HALF && !(a == `OFF_UNLOCK_KEY && wb_req.dat == `UNLOCK_KEY_SECOND))
    |=> key_state == pin_route_pkg::KEY_IDLE)
    else $error("Broken key sequence did not start over.");

  a_key_open_once: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && key_state == pin_route_pkg::KEY_OPEN) |=> key_state == pin_route_pkg::KEY_IDLE)
    else $error("Unlock window stayed open after a write.");

  // Lock bit: changes only in the open window; once set under single-session it stays set.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      map_write_lock <= 1'b0;
      lock_was_set <= 1'b0;
    end else if (wr && a == `OFF_CONFIG_CONTROL && key_state == pin_route_pkg::KEY_OPEN) begin
      if (wb_req.dat[`BIT_MAP_WRITE_LOCK]) begin
        map_write_lock <= 1'b1;
        lock_was_set <= 1'b1;
      end else if (!(one_way && lock_was_set)) begin
        map_write_lock <= 1'b0;
      end
    end
  end

  // The lock can only move in the one-write window that the key sequence opens.
  a_lock_needs_key: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(map_write_lock) |-> $past(key_state) == pin_route_pkg::KEY_OPEN)
    else $error("Lock changed without the unlock sequence.");

  a_lock_set_open: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && a == `OFF_CONFIG_CONTROL && key_state == pin_route_pkg::KEY_OPEN && wb_req.dat[`BIT_MAP_WRITE_LOCK])
    |=> map_write_lock)
    else $error("Unlocked write did not set the lock bit.");

  // Under the single-session lock a set lock stays set until the next reset.
  a_one_way_stays: assert property (@(posedge core_clk) disable iff (!rst_n)
    (one_way && lock_was_set) |=> map_write_lock)
    else $error("Lock cleared in single-session mode.");

  ////////////////////////////////////////////////////////////////////////////
  // Select registers; writes under the lock are acknowledged and dropped.
  genvar gi;
  generate
    for (gi = 0; gi < `N_IN_SEL; gi++) begin : g_in
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          in_sel[gi] <= `SEL_RESET;
        end else if (wr && !map_write_lock && wb_req.sel[0] && a == `OFF_IN_SEL_BASE + 8'(4 * gi)) begin
          in_sel[gi] <= wb_req.dat[`SEL_W-1:0];
        end
      end

      // Reserved codes and pins missing on the small package read as inactive low.
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          periph_in[gi] <= 1'b0;
        end else if (in_sel[gi] >= `FIRST_RESERVED_CODE) begin
          periph_in[gi] <= 1'b0;
        end else if (small_pkg && in_sel[gi] >= `FIRST_RESTRICTED_CODE) begin
          periph_in[gi] <= 1'b0;
        end else begin
          periph_in[gi] <= pin_sync[in_sel[gi]];
        end
      end
    end

    for (gi = 0; gi < `N_OUT_PIN; gi++) begin : g_out
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          out_sel[gi] <= `SEL_RESET;
        end else if (wr && !map_write_lock && wb_req.sel[0] && a == `OFF_OUT_SEL_BASE + 8'(4 * gi)) begin
          out_sel[gi] <= wb_req.dat[`SEL_W-1:0];
        end
      end

      // Code 0 is the null output: pin undriven; other codes pick one peripheral output.
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_out[gi] <= 1'b0;
          pin_oe[gi] <= 1'b0;
        end else begin
          pin_oe[gi] <= (out_sel[gi] != `SEL_RESET);
          pin_out[gi] <= (out_sel[gi] != `SEL_RESET) ? periph_out[out_sel[gi]] : 1'b0;
        end
      end
    end
  endgenerate

  // Spot checks on inputs 0 and 2 and on the first and last pins; the generate loops make the rest alike.
  a_in_write_lands: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && !map_write_lock && wb_req.sel[0] && a == `OFF_IN_SEL_BASE)
    |=> in_sel[0] == $past(wb_req.dat[`SEL_W-1:0]))
    else $error("Unlocked input select write was lost.");

  a_in_locked_held: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && map_write_lock && a == `OFF_IN_SEL_BASE) |=> $stable(in_sel[0]))
    else $error("Input select changed while the map was locked.");

  a_locked_write_held: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && map_write_lock && a == `OFF_OUT_SEL_BASE) |=> $stable(out_sel[0]))
    else $error("Select changed while the map was locked.");

  a_out_write_lands: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && !map_write_lock && wb_req.sel[0] && a == `OFF_OUT_SEL_BASE)
    |=> out_sel[0] == $past(wb_req.dat[`SEL_W-1:0]))
    else $error("Unlocked output select write was lost.");

  a_null_output_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (out_sel[0] == `SEL_RESET) |=> !pin_oe[0])
    else $error("Null output still drives the pin.");

  a_oe_needs_select: assert property (@(posedge core_clk) disable iff (!rst_n)
    pin_oe[12] |-> $past(out_sel[12]) != `SEL_RESET)
    else $error("Pin driven without a selected output.");

  a_output_routed: assert property (@(posedge core_clk) disable iff (!rst_n)
    (out_sel[0] != `SEL_RESET) |=> (pin_oe[0] && pin_out[0] == $past(periph_out[out_sel[0]])))
    else $error("Pin does not follow its selected output.");

  a_reserved_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    (in_sel[0] >= `FIRST_RESERVED_CODE) |=> !periph_in[0])
    else $error("Reserved input code not inactive.");

  a_small_pkg_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    (small_pkg && in_sel[0] >= `FIRST_RESTRICTED_CODE) |=> !periph_in[0])
    else $error("Absent pin reached an input.");

  a_small_pkg_routes: assert property (@(posedge core_clk) disable iff (!rst_n)
    (small_pkg && in_sel[0] < `FIRST_RESTRICTED_CODE) |=> periph_in[0] == $past(pin_sync[in_sel[0]]))
    else $error("Present pin not routed on the small package.");

  a_input_routed: assert property (@(posedge core_clk) disable iff (!rst_n)
    (in_sel[2] < `FIRST_RESTRICTED_CODE) |=> periph_in[2] == $past(pin_sync[in_sel[2]]))
    else $error("Input does not follow its selected pin.");

  // Two-flop synchroniser: only the second stage feeds the input routing.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: ack one cycle after the request, unmapped reads return zero.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= '0;
      if (req && !wb_req.we) begin
        if (a == `OFF_CONFIG_CONTROL) begin
          wb_dat_o[`BIT_MAP_WRITE_LOCK] <= map_write_lock;
        end else if (a == `OFF_STATUS) begin
          wb_dat_o[2:0] <= {small_pkg, one_way, key_state == pin_route_pkg::KEY_OPEN};
        end else if (a >= `OFF_IN_SEL_BASE && a < `OFF_IN_SEL_BASE + 8'(4 * `N_IN_SEL) && a[1:0] == 2'b00) begin
          wb_dat_o[`SEL_W-1:0] <= in_sel[5'(a[7:2] - 6'(`OFF_IN_SEL_BASE >> 2))];
        end else if (a >= `OFF_OUT_SEL_BASE && a < `OFF_OUT_SEL_BASE + 8'(4 * `N_OUT_PIN) && a[1:0] == 2'b00) begin
          wb_dat_o[`SEL_W-1:0] <= out_sel[4'(a[7:2] - 6'(`OFF_OUT_SEL_BASE >> 2))];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The answer is one registered cycle; the key port never echoes what was written to it.
  a_ack_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
    req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus answer not one cycle after request.");

  a_ack_from_request: assert property (@(posedge core_clk) disable iff (!rst_n)
    wb_ack_o |-> $past(req))
    else $error("Bus answer without a request.");

  a_read_lock_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
    (req && !wb_req.we && a == `OFF_CONFIG_CONTROL)
    |=> wb_dat_o[`BIT_MAP_WRITE_LOCK] == $past(map_write_lock))
    else $error("Control read does not show the lock bit.");

  a_key_port_blind: assert property (@(posedge core_clk) disable iff (!rst_n)
    (req && !wb_req.we && a == `OFF_UNLOCK_KEY) |=> wb_dat_o == 32'h0)
    else $error("Key port read back nonzero.");

endmodule
`default_nettype wire

// >>> bench/pin_side_model.sv
/*
 Far-side model: pin levels and peripheral outputs, registered from bench requests.
 Assumes one core_clk domain shared with the routing block.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pin_route_consts.svh"
module pin_side_model (
  // Clock.
  input wire logic core_clk,
  // Requested levels.
  input wire logic [`N_PINS-1:0] pin_set,
  input wire logic [`N_PERIPH_OUT-1:0] periph_set,
  // Driven levels.
  output logic [`N_PINS-1:0] pin_in,
  output logic [`N_PERIPH_OUT-1:0] periph_out
);
  always_ff @(posedge core_clk) begin
    pin_in <= pin_set;
    periph_out <= periph_set;
  end
endmodule
`default_nettype wire

// >>> bench/tb_remappable_pin_routing.sv
/*
 Self-checking bench for remappable_pin_routing, driving a classic Wishbone master.
 Assumes the package, the design and pin_side_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pin_route_consts.svh"
module tb_remappable_pin_routing;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic session_strap = 1'b1;
  logic pkg_strap = 1'b0;
  pin_route_pkg::wb_req_t wb_req = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [`N_PINS-1:0] pin_in;
  logic [`N_PINS-1:0] pin_set = '0;
  logic [`N_PERIPH_OUT-1:0] periph_out;
  logic [`N_PERIPH_OUT-1:0] periph_set = '0;
  logic [`N_OUT_PIN-1:0] pin_out;
  logic [`N_OUT_PIN-1:0] pin_oe;
  logic [`N_IN_SEL-1:0] periph_in;
  logic [31:0] rd;
  int bad_count = 0;
  int samples_checked = 0;

  always #5 core_clk = ~core_clk;

  remappable_pin_routing u_dut (.core_clk(core_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .single_session_lock(session_strap), .pkg_64_pin(pkg_strap), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(periph_out), .periph_in(periph_in));
  pin_side_model u_far (.core_clk(core_clk), .pin_set(pin_set), .periph_set(periph_set),
    .pin_in(pin_in), .periph_out(periph_out));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic cycle; the request holds until ack is sampled high.
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    logic got;
    n = 0;
    wb_req <= '{adr: {24'h0, adr}, dat: dat, sel: 4'hf, we: we, cyc: 1'b1, stb: 1'b1};
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    got = (wb_ack_o === 1'b1);
    rd = wb_dat_o;
    wb_req <= '0;
    @(posedge core_clk);
    if (!got) begin
      bad_count++;
      finish_test();
    end
  endtask

  task automatic unlock(input logic [31:0] ctl);
    bus(1'b1, `OFF_UNLOCK_KEY, `UNLOCK_KEY_FIRST);
    bus(1'b1, `OFF_UNLOCK_KEY, `UNLOCK_KEY_SECOND);
    bus(1'b1, `OFF_CONFIG_CONTROL, ctl);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check("pin_oe", pin_oe, 32'h0);
    bus(1'b0, `OFF_STATUS, 32'h0);
    check("status", rd, 32'h2);
  endtask

  task automatic t_open;
    unlock(32'h0);
    bus(1'b1, `OFF_CONFIG_CONTROL, 32'h2000);
    bus(1'b0, `OFF_CONFIG_CONTROL, 32'h0);
    check("lock", rd[13], 32'h0);
  endtask

  task automatic t_inputs;
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, `OFF_IN_SEL_BASE, c);
      pin_set <= (c < 14) ? 14'h1 << c : '1;
      repeat (5) @(posedge core_clk);
      check("periph_in hi", periph_in[0], c < 14);
      pin_set <= ~pin_set;
      repeat (5) @(posedge core_clk);
      check("periph_in lo", periph_in[0], 32'h0);
    end
  endtask

  task automatic t_outputs;
    for (int k = 0; k < 16; k++) begin
      bus(1'b1, `OFF_OUT_SEL_BASE, k);
      periph_set <= 16'h1 << k;
      repeat (3) @(posedge core_clk);
      check("pin_oe", pin_oe[0], k != 0);
      check("pin_out hi", pin_out[0], k != 0);
      periph_set <= ~(16'h1 << k);
      repeat (3) @(posedge core_clk);
      check("pin_out lo", pin_out[0], 32'h0);
    end
    bus(1'b1, `OFF_OUT_SEL_BASE + 8'h30, 32'h3);
    bus(1'b0, `OFF_OUT_SEL_BASE + 8'h30, 32'h0);
    check("out sel", rd, 32'h3);
    check("pin_oe", pin_oe, 32'h1001);
  endtask

  task automatic t_lock;
    unlock(32'h2000);
    bus(1'b1, `OFF_IN_SEL_BASE, 32'h7);
    bus(1'b0, `OFF_IN_SEL_BASE, 32'h0);
    check("in sel", rd, 32'hf);
    unlock(32'h0);
    bus(1'b0, `OFF_CONFIG_CONTROL, 32'h0);
    check("lock", rd[13], 32'h1);
  endtask

  // A second reset with the other strap settings: the small package and a lock that may be cleared.
  task automatic t_session;
    session_strap <= 1'b0;
    pkg_strap <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("pin_oe", pin_oe, 32'h0);
    bus(1'b0, `OFF_STATUS, 32'h0);
    check("status", rd, 32'h4);
    bus(1'b1, `OFF_IN_SEL_BASE, 32'h5);
    bus(1'b0, `OFF_IN_SEL_BASE, 32'h0);
    check("in sel", rd, 32'h5);
    for (int c = 10; c < 14; c++) begin
      bus(1'b1, `OFF_IN_SEL_BASE, c);
      pin_set <= '1;
      repeat (5) @(posedge core_clk);
      check("periph_in small", periph_in[0], c < 11);
    end
    unlock(32'h2000);
    unlock(32'h0);
    bus(1'b0, `OFF_CONFIG_CONTROL, 32'h0);
    check("lock", rd[13], 32'h0);
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_reset();
    t_open();
    t_inputs();
    t_outputs();
    t_lock();
    t_session();
    finish_test();
  end
endmodule
`default_nettype wire
